// ===== core/jfp_pkg.sv
package jfp_pkg;

    localparam int IR_W       = 4;
    localparam int CMD_W      = 15;
    localparam int BYTE_W     = 8;
    localparam int EN_W       = 16;
    localparam int WORD_W     = 16;
    localparam int PC_W       = 16;
    localparam int FIFO_DEPTH = 16;

    localparam logic [IR_W-1:0] PROG_ENABLE_INSTR      = 4'h4;
    localparam logic [IR_W-1:0] COMMAND_ENTRY_INSTR    = 4'h5;
    localparam logic [IR_W-1:0] PAGE_BUFFER_LOAD_INSTR = 4'h6;
    localparam logic [IR_W-1:0] PAGE_READBACK_INSTR    = 4'h7;
    localparam logic [IR_W-1:0] IR_BYPASS              = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE             = 4'h1;

    localparam logic [EN_W-1:0] EN_SIGNATURE = 16'hA370;

    // Sampled pin bit positions
    localparam int PIN_TCK = 0;
    localparam int PIN_TMS = 1;
    localparam int PIN_TDI = 2;
    localparam int PIN_N   = 3;

    localparam int BYTE_LO = 0;
    localparam int BYTE_HI = 8;

    // Timing: longest write time rounds down to whole cycles
    localparam int CLK_NS       = 20;
    localparam int TCK_NS       = 160;
    localparam int WR_TCK       = 11;
    localparam int WR_LIMIT_CYC = (WR_TCK * TCK_NS) / CLK_NS;

    typedef enum logic [15:0] {
        TAP_TLR    = 16'h0001,
        TAP_RTI    = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PA_DR  = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PA_IR  = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } jfp_tap_e;

endpackage

// ===== core/jfp_fifo_if.sv
`timescale 1ns/10ps
interface jfp_fifo_if #(
    parameter int W = 8
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport user (
        output push_valid,
        output push_data,
        input  push_ready,
        input  pop_valid,
        input  pop_data,
        output pop_ready
    );

    modport store (
        input  push_valid,
        input  push_data,
        output push_ready,
        output pop_valid,
        output pop_data,
        input  pop_ready
    );
endinterface

// ===== core/jfp_fifo.sv
`timescale 1ns/10ps
module jfp_fifo
    import jfp_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic clk,
    input  wire logic nrst,
    jfp_fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } jfp_fifo_s;

    jfp_fifo_s st;
    jfp_fifo_s nxt;
    logic      push;
    logic      pop;

    // Head word comes straight from storage flops
    assign bus.push_ready = (st.cnt != (AW+1)'(DEPTH));
    assign bus.pop_valid  = (st.cnt != '0);
    assign bus.pop_data   = st.mem[st.rp];
    assign push           = bus.push_valid & bus.push_ready;
    assign pop            = bus.pop_valid & bus.pop_ready;

    always_comb begin
        nxt = st;
        if (push) begin
            nxt.mem[st.wp] = bus.push_data;
            nxt.wp         = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            nxt.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        case ({push, pop})
            2'b10:   nxt.cnt = st.cnt + 1'b1;
            2'b01:   nxt.cnt = st.cnt - 1'b1;
            default: nxt.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end
endmodule

// ===== core/jfp_prog_path.sv
`timescale 1ns/10ps
// Function
// - The command-entry instruction puts the 15-bit command shift register between TDI and TDO.
// - Capture-DR under command entry loads the previous command's result into the command register.
// - Shift-DR under command entry shifts once per TCK, result out on TDO while the next command comes in.
// - Update-DR under command entry presents the shifted-in command to the flash inputs.
// - Passing Run-Test/Idle after a command update gives one internal execute clock.
// - Page load selects an 8-bit page-byte register made of the low eight command register bits.
// - Under page load or page read the page-byte register shifts one bit per TCK in Shift-DR.
// - Each page-load Update-DR copies the byte into a holding register and writes it to the page buffer within 11 TCK;
//   here the byte waits in the holding register without limit while the FIFO is full.
// - Page-load updates alternate low and high byte, the first after entering the instruction being low.
// - The word address steps before each page-load low byte except the first.
// - Page read selects the same 8-bit page-byte register from the low command register bits.
// - Each page-read Capture-DR loads the addressed flash byte, alternating low then high, low first.
// - The word address steps after every page-read high byte, the first included.
// - The instruction register is four bits wide.
// - Every scan register shifts least significant bit first, in and out.
// - Programming works only after the 16-bit enable register holds the enable signature.
module jfp_prog_path
    import jfp_pkg::*;
#(
    parameter int ADDR_W = PC_W,
    parameter int DEPTH  = FIFO_DEPTH
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe_n,
    output logic [CMD_W-1:0]       cmd_word,
    output logic                   cmd_valid,
    output logic                   cmd_exec,
    input  wire logic [CMD_W-1:0]  cmd_result,
    output logic                   prog_enabled,
    input  wire logic [ADDR_W-1:0] addr_preset,
    input  wire logic              addr_load,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [WORD_W-1:0] rd_data,
    output logic                   pb_valid,
    input  wire logic              pb_ready,
    output logic                   pb_hi,
    output logic [ADDR_W-1:0]      pb_addr,
    output logic [BYTE_W-1:0]      pb_byte
);
    localparam int FW     = 1 + ADDR_W + BYTE_W;
    localparam int WR_LIM = WR_LIMIT_CYC;

    typedef struct packed {
        logic [PIN_N-1:0]  s1;
        logic [PIN_N-1:0]  s2;
        logic              tck_d;
        jfp_tap_e          tap;
        logic [IR_W-1:0]   ir;
        logic [IR_W-1:0]   ir_sr;
        logic [CMD_W-1:0]  cmd_sr;
        logic [EN_W-1:0]   en_sr;
        logic              byp;
        logic              prog_en;
        logic              tdo;
        logic              oe_n;
        logic [CMD_W-1:0]  cmd_word;
        logic              cmd_valid;
        logic              cmd_exec;
        logic              exec_arm;
        logic              hi;
        logic              first;
        logic [ADDR_W-1:0] pc;
        logic              pend;
        logic [FW-1:0]     hold;
    } jfp_st_s;

    jfp_st_s st;
    jfp_st_s nxt;
    logic    tck_rise;
    logic    tck_fall;
    logic    tms_s;
    logic    tdi_s;
    logic    dr_lsb;

    jfp_fifo_if #(.W(FW)) fbus ();

    jfp_fifo #(
        .W     (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk  (clk),
        .nrst (nrst),
        .bus  (fbus)
    );

    function automatic jfp_tap_e tap_next(input jfp_tap_e s, input logic m);
        case (s)
            TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            default:    tap_next = TAP_TLR;
        endcase
    endfunction

    // Both page instructions share the low byte of the command register
    function automatic logic is_page(input logic [IR_W-1:0] op);
        is_page = (op == PAGE_BUFFER_LOAD_INSTR) || (op == PAGE_READBACK_INSTR);
    endfunction

    // Edge detect looks at the second stage only
    assign tck_rise = st.s2[PIN_TCK] & ~st.tck_d;
    assign tck_fall = ~st.s2[PIN_TCK] & st.tck_d;
    assign tms_s    = st.s2[PIN_TMS];
    assign tdi_s    = st.s2[PIN_TDI];

    always_comb begin
        if (st.ir == COMMAND_ENTRY_INSTR || is_page(st.ir)) begin
            dr_lsb = st.cmd_sr[0];
        end else if (st.ir == PROG_ENABLE_INSTR) begin
            dr_lsb = st.en_sr[0];
        end else begin
            dr_lsb = st.byp;
        end
    end

    always_comb begin
        nxt           = st;
        nxt.s1        = {tdi, tms, tck};
        nxt.s2        = st.s1;
        nxt.tck_d     = st.s2[PIN_TCK];
        nxt.cmd_valid = 1'b0;
        nxt.cmd_exec  = 1'b0;
        // Holding register waits here while the buffer is full
        if (st.pend && fbus.push_ready) begin
            nxt.pend = 1'b0;
        end
        if (addr_load) begin
            nxt.pc = addr_preset;
        end
        if (tck_rise) begin
            nxt.tap = tap_next(st.tap, tms_s);
            case (st.tap)
                TAP_TLR: begin
                    nxt.ir       = IR_BYPASS;
                    nxt.hi       = 1'b0;
                    nxt.first    = 1'b1;
                    nxt.exec_arm = 1'b0;
                end
                TAP_RTI: begin
                    if (st.exec_arm) begin
                        nxt.cmd_exec = 1'b1;
                        nxt.exec_arm = 1'b0;
                    end
                end
                TAP_CAP_IR: begin
                    nxt.ir_sr = IR_CAPTURE;
                end
                TAP_SH_IR: begin
                    nxt.ir_sr = {tdi_s, st.ir_sr[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    nxt.ir       = st.ir_sr;
                    nxt.hi       = 1'b0;
                    nxt.first    = 1'b1;
                    nxt.exec_arm = 1'b0;
                end
                TAP_CAP_DR: begin
                    if (st.ir == COMMAND_ENTRY_INSTR && st.prog_en) begin
                        nxt.cmd_sr = cmd_result;
                    end else if (st.ir == PAGE_READBACK_INSTR && st.prog_en) begin
                        nxt.cmd_sr[BYTE_W-1:0] = st.hi ? rd_data[BYTE_HI +: BYTE_W]
                                                       : rd_data[BYTE_LO +: BYTE_W];
                        nxt.hi = ~st.hi;
                        if (st.hi) begin
                            nxt.pc = st.pc + 1'b1;
                        end
                    end else begin
                        nxt.byp = 1'b0;
                    end
                end
                TAP_SH_DR: begin
                    if (st.ir == COMMAND_ENTRY_INSTR) begin
                        nxt.cmd_sr = {tdi_s, st.cmd_sr[CMD_W-1:1]};
                    end else if (is_page(st.ir)) begin
                        nxt.cmd_sr[BYTE_W-1:0] = {tdi_s, st.cmd_sr[BYTE_W-1:1]};
                    end else if (st.ir == PROG_ENABLE_INSTR) begin
                        nxt.en_sr = {tdi_s, st.en_sr[EN_W-1:1]};
                    end else begin
                        nxt.byp = tdi_s;
                    end
                end
                TAP_UPD_DR: begin
                    if (st.ir == PROG_ENABLE_INSTR) begin
                        nxt.prog_en = (st.en_sr == EN_SIGNATURE);
                    end else if (st.ir == COMMAND_ENTRY_INSTR && st.prog_en) begin
                        nxt.cmd_word  = st.cmd_sr;
                        nxt.cmd_valid = 1'b1;
                        nxt.exec_arm  = 1'b1;
                    end else if (st.ir == PAGE_BUFFER_LOAD_INSTR && st.prog_en) begin
                        if (!st.hi && !st.first) begin
                            nxt.pc = st.pc + 1'b1;
                        end
                        nxt.hold  = {st.hi, nxt.pc, st.cmd_sr[BYTE_W-1:0]};
                        nxt.pend  = 1'b1;
                        nxt.hi    = ~st.hi;
                        nxt.first = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // TDO moves on the falling edge so the host samples a settled bit
        if (tck_fall) begin
            nxt.oe_n = ~(st.tap == TAP_SH_DR || st.tap == TAP_SH_IR);
            nxt.tdo  = (st.tap == TAP_SH_IR) ? st.ir_sr[0] : dr_lsb;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st       <= '0;
            st.tap   <= TAP_TLR;
            st.ir    <= IR_BYPASS;
            st.first <= 1'b1;
            st.oe_n  <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    assign fbus.push_valid = st.pend;
    assign fbus.push_data  = st.hold;
    assign fbus.pop_ready  = pb_ready;
    assign pb_valid        = fbus.pop_valid;
    assign {pb_hi, pb_addr, pb_byte} = fbus.pop_data;

    assign tdo          = st.tdo;
    assign tdo_oe_n     = st.oe_n;
    assign cmd_word     = st.cmd_word;
    assign cmd_valid    = st.cmd_valid;
    assign cmd_exec     = st.cmd_exec;
    assign prog_enabled = st.prog_en;
    assign rd_addr      = st.pc;

    a_exec_in_idle: assert property (@(posedge clk) disable iff (!nrst)
        cmd_exec |-> $past(st.tap) == TAP_RTI && $past(st.exec_arm) && !st.exec_arm && !$past(cmd_exec))
        else $error("execute pulse outside idle or repeated");

    a_cmd_applied: assert property (@(posedge clk) disable iff (!nrst)
        cmd_valid |-> cmd_word == $past(st.cmd_sr) && $past(st.tap) == TAP_UPD_DR && prog_enabled)
        else $error("command word not applied from shift register");

    a_cmd_capture: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_CAP_DR && st.ir == COMMAND_ENTRY_INSTR && st.prog_en)
        |=> st.cmd_sr == $past(cmd_result))
        else $error("command result not captured");

    a_cmd_shift: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_SH_DR && st.ir == COMMAND_ENTRY_INSTR)
        |=> st.cmd_sr == {$past(tdi_s), $past(st.cmd_sr[CMD_W-1:1])})
        else $error("command register not shifted lsb first");

    a_page_upper: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_SH_DR && is_page(st.ir))
        |=> $stable(st.cmd_sr[CMD_W-1:BYTE_W]) && st.cmd_sr[BYTE_W-1] == $past(tdi_s))
        else $error("page byte shift disturbed upper bits");

    a_wr_deadline: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st.pend) |-> ##[1:WR_LIM] !st.pend)
        else $error("page buffer write not done within limit");

    a_ir_low_start: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_UPD_IR) |=> !st.hi && st.first)
        else $error("byte toggle not cleared on instruction load");

    a_load_step: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_UPD_DR && st.ir == PAGE_BUFFER_LOAD_INSTR && st.prog_en && !addr_load)
        |=> st.pc == ($past(st.pc) + (($past(st.hi) || $past(st.first)) ? 1'b0 : 1'b1))
            && st.hi != $past(st.hi))
        else $error("page load address step wrong");

    a_read_step: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_CAP_DR && st.ir == PAGE_READBACK_INSTR && st.prog_en && !addr_load)
        |=> st.pc == ($past(st.pc) + ($past(st.hi) ? 1'b1 : 1'b0)))
        else $error("page read address step wrong");

    a_read_byte: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_CAP_DR && st.ir == PAGE_READBACK_INSTR && st.prog_en && !st.hi)
        |=> st.cmd_sr[BYTE_W-1:0] == $past(rd_data[BYTE_LO +: BYTE_W]) && st.hi)
        else $error("low byte not captured first");

    a_enable_gate: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st.pend) || cmd_valid |-> st.prog_en)
        else $error("programming action without enable");

    a_oe_shift_only: assert property (@(posedge clk) disable iff (!nrst)
        !tdo_oe_n |-> st.tap inside {TAP_SH_DR, TAP_SH_IR, TAP_EX1_DR, TAP_EX1_IR})
        else $error("tdo driven outside shift");

    a_tdo_fall_only: assert property (@(posedge clk) disable iff (!nrst)
        !$past(tck_fall) |-> $stable(tdo))
        else $error("tdo moved away from a falling tck");

    a_ir_capture: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_CAP_IR) |=> st.ir_sr == IR_CAPTURE)
        else $error("instruction capture value wrong");

    a_ir_load: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_UPD_IR) |=> st.ir == $past(st.ir_sr))
        else $error("instruction not loaded from shift register");

    a_enable_compare: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_UPD_DR && st.ir == PROG_ENABLE_INSTR)
        |=> st.prog_en == ($past(st.en_sr) == EN_SIGNATURE))
        else $error("enable flag does not follow signature compare");

    a_hold_copy: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_UPD_DR && st.ir == PAGE_BUFFER_LOAD_INSTR && st.prog_en)
        |=> st.pend && st.hold[BYTE_W-1:0] == $past(st.cmd_sr[BYTE_W-1:0]))
        else $error("page byte not copied to holding register");

    a_read_high: assert property (@(posedge clk) disable iff (!nrst)
        (tck_rise && st.tap == TAP_CAP_DR && st.ir == PAGE_READBACK_INSTR && st.prog_en && st.hi)
        |=> st.cmd_sr[BYTE_W-1:0] == $past(rd_data[BYTE_HI +: BYTE_W]) && !st.hi)
        else $error("high byte not captured second");

    a_cmd_hold: assert property (@(posedge clk) disable iff (!nrst)
        !cmd_valid |-> $stable(cmd_word))
        else $error("command word changed without valid");

    a_first_low: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st.pend) && $past(st.first) |-> !st.hold[FW-1])
        else $error("first page byte not low");
endmodule

// ===== verif/jfp_host.sv
`timescale 1ns/10ps
module jfp_host (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    logic tdi_last;

    initial begin
        tck      = 1'b0;
        tms      = 1'b1;
        tdi      = 1'b0;
        tdi_last = 1'b0;
    end

    // One TCK period of 8 clk; TCK rests low between calls
    task automatic pulse(input logic m, input logic d, input logic shifting, output logic q);
        @(posedge clk);
        tms <= m;
        // Outside shift the line carries no meaning, so it keeps moving
        tdi <= shifting ? d : ~tdi_last;
        tdi_last = shifting ? d : ~tdi_last;
        repeat (3) @(posedge clk);
        tck <= 1'b1;
        // Sampled late in the high phase; tdo only moves after the fall
        repeat (3) @(posedge clk);
        q = tdo;
        @(posedge clk);
        tck <= 1'b0;
    endtask

    task automatic tap_reset();
        logic q;
        repeat (5) pulse(1'b1, 1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, 1'b0, q);
    endtask

    // Starts and ends in Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, 1'b0, 1'b0, q);
        if (ir) pulse(1'b1, 1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        pulse(1'b1, 1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, 1'b0, q);
    endtask
endmodule

// ===== verif/jtag_flash_program_path_tb.sv
`timescale 1ns/10ps
module jtag_flash_program_path_tb
    import jfp_pkg::*;
;
    logic              clk, nrst, tck, tms, tdi, tdo, tdo_oe_n;
    logic [CMD_W-1:0]  cmd_word, cmd_result;
    logic              cmd_valid, cmd_exec, prog_enabled, addr_load;
    logic [PC_W-1:0]   addr_preset, rd_addr, pb_addr;
    logic [WORD_W-1:0] rd_data;
    logic              pb_valid, pb_ready, pb_hi, stall;
    logic [BYTE_W-1:0] pb_byte;
    logic [31:0]       seed;
    logic [24:0]       rx[$];
    logic [7:0]        lb[0:FIFO_DEPTH+1];
    int                errors, checks, n_valid, n_exec, n_oe, cyc;

    jfp_prog_path dut (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .cmd_word(cmd_word), .cmd_valid(cmd_valid), .cmd_exec(cmd_exec),
        .cmd_result(cmd_result), .prog_enabled(prog_enabled), .addr_preset(addr_preset),
        .addr_load(addr_load), .rd_addr(rd_addr), .rd_data(rd_data), .pb_valid(pb_valid),
        .pb_ready(pb_ready), .pb_hi(pb_hi), .pb_addr(pb_addr), .pb_byte(pb_byte));

    jfp_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] flash_word(input logic [15:0] a);
        return {a[7:0] ^ 8'hA5, a[15:8] + a[7:0]};
    endfunction

    function automatic logic [24:0] exp_entry(input logic [15:0] base, input int k, input logic [7:0] b);
        return {k % 2 == 1, base + 16'(k / 2), b};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic set_addr(input logic [15:0] a);
        @(posedge clk);
        addr_preset <= a;
        addr_load   <= 1'b1;
        @(posedge clk);
        addr_load   <= 1'b0;
    endtask

    task automatic wait_rx(input int n, input int limit);
        for (int t = 0; t < limit && rx.size() < n; t++) @(posedge clk);
    endtask

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // Page buffer side stalls at random; flash answers the current word
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
        pb_ready <= !stall && (rnd() % 3 != 0);
        rd_data  <= flash_word(rd_addr);
    end

    // Outputs read mid-cycle, away from the edge that moves them
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) n_valid++;
        if (cmd_exec === 1'b1) n_exec++;
        if (tdo_oe_n === 1'b0) n_oe++;
        if (pb_valid === 1'b1 && pb_ready === 1'b1) rx.push_back({pb_hi, pb_addr, pb_byte});
    end

    initial begin
        logic [15:0] d;
        logic [15:0] c;
        logic [15:0] p;
        logic [7:0]  prev;
        seed = 32'd42197;
        errors = 0; checks = 0; n_valid = 0; n_exec = 0; cyc = 0;
        nrst = 1'b0; stall = 1'b0; pb_ready = 1'b0; rd_data = '0;
        cmd_result = '0; addr_preset = '0; addr_load = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        host.tap_reset();
        chk("tdo_oe_n idle", 1, tdo_oe_n);
        chk("prog_enabled reset", 0, prog_enabled);
        chk("pb_valid reset", 0, pb_valid);
        $display("test reset done");

        host.scan(1'b1, IR_W, {12'h000, COMMAND_ENTRY_INSTR}, d);
        chk("ir capture", IR_CAPTURE, d[3:0]);
        host.scan(1'b0, CMD_W, 16'h1234, d);
        chk("cmd_valid while locked", 0, n_valid);
        host.scan(1'b1, IR_W, {12'h000, PROG_ENABLE_INSTR}, d);
        host.scan(1'b0, EN_W, EN_SIGNATURE ^ 16'h0100, d);
        chk("prog_enabled bad key", 0, prog_enabled);
        host.scan(1'b0, EN_W, EN_SIGNATURE, d);
        chk("prog_enabled good key", 1, prog_enabled);
        $display("test enable done");

        host.scan(1'b1, IR_W, {12'h000, COMMAND_ENTRY_INSTR}, d);
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 16'h7FFF : 16'(rnd());
            p = (k == 0) ? 16'h0001 : 16'(rnd());
            @(posedge clk);
            cmd_result <= p[14:0];
            n_oe = 0;
            host.scan(1'b0, CMD_W, {1'b0, c[14:0]}, d);
            chk("tdo_oe_n low cycles", CMD_W * TCK_NS / CLK_NS, n_oe);
            chk("shifted result", p[14:0], d[14:0]);
            chk("cmd_word", c[14:0], cmd_word);
            chk("cmd_valid count", k + 1, n_valid);
            chk("cmd_exec count", k + 1, n_exec);
        end
        prev = c[7:0];
        $display("test command done");

        set_addr(16'h0120);
        stall <= 1'b1;
        host.scan(1'b1, IR_W, {12'h000, PAGE_BUFFER_LOAD_INSTR}, d);
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            c = 16'(rnd());
            lb[k] = c[7:0];
            host.scan(1'b0, BYTE_W, c, d);
            chk("page byte out", prev, d[7:0]);
            prev = c[7:0];
        end
        chk("stalled pops", 0, rx.size());
        chk("fifo head valid", 1, pb_valid);
        stall <= 1'b0;
        wait_rx(FIFO_DEPTH + 1, 600);
        chk("drained count", FIFO_DEPTH + 1, rx.size());
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            chk("page entry", exp_entry(16'h0120, k, lb[k]), rx[k]);
        end
        chk("rd_addr after load", 16'h0128, rd_addr);
        host.scan(1'b1, IR_W, {12'h000, COMMAND_ENTRY_INSTR}, d);
        host.scan(1'b1, IR_W, {12'h000, PAGE_BUFFER_LOAD_INSTR}, d);
        lb[FIFO_DEPTH + 1] = 8'h00;
        host.scan(1'b0, BYTE_W, 16'h0000, d);
        wait_rx(FIFO_DEPTH + 2, 72);
        chk("reentry count", FIFO_DEPTH + 2, rx.size());
        chk("reentry entry", exp_entry(16'h0128, 0, 8'h00), rx[FIFO_DEPTH + 1]);
        $display("test page load done");

        set_addr(16'h03FE);
        host.scan(1'b1, IR_W, {12'h000, PAGE_READBACK_INSTR}, d);
        for (int k = 0; k < 5; k++) begin
            host.scan(1'b0, BYTE_W, 16'(rnd()), d);
            p = flash_word(16'h03FE + 16'(k / 2));
            chk("read byte", (k % 2 == 1) ? p[15:8] : p[7:0], d[7:0]);
        end
        chk("rd_addr after read", 16'h0400, rd_addr);
        chk("no writes in read", FIFO_DEPTH + 2, rx.size());
        $display("test page read done");
        results();
    end
endmodule
